/* File: rtl/irq_temp_pkg.sv */
// Shared constants and types for the interrupt release and temperature sequencer.
// Assumes one master clock drives all device logic and the serial pins arrive asynchronously.
package irq_temp_pkg;

   // Serial register addresses, six bits wide.
   localparam logic [5:0] ADDR_MODE      = 6'h09;
   localparam logic [5:0] ADDR_IRQ_EN    = 6'h0A;
   localparam logic [5:0] ADDR_STATUS    = 6'h0B;
   localparam logic [5:0] ADDR_STAT_CLR  = 6'h0C;
   localparam logic [5:0] ADDR_TEMP      = 6'h20;

   // Field positions.
   localparam int         CMD_WRITE_BIT  = 7;
   localparam int         MODE_TEMP_BIT  = 5;
   localparam int         TEMP_EVENT_BIT = 5;

   // Values after reset.
   localparam logic [15:0] MODE_RESET    = 16'h0000;
   localparam logic [15:0] IRQ_EN_RESET  = 16'h0000;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam logic [7:0]  TEMP_RESET    = 8'h00;

   // Transfer lengths in serial clock bits.
   localparam logic [4:0] CMD_BITS         = 5'h08;
   localparam logic [4:0] WIDE_REG_BITS    = 5'h10;
   localparam logic [4:0] TEMP_REG_BITS    = 5'h08;
   localparam logic [4:0] STATUS_HOLD_BITS = 5'h0F;

   // Conversion time in master clock periods; one period equals one clk cycle.
   localparam int         TEMP_MCLK_PERIODS = 96;
   localparam int         TEMP_CYCLES       = TEMP_MCLK_PERIODS * 1;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } spi_pins_type;

   typedef enum logic [1:0] {
      PHASE_CMD,
      PHASE_WRITE,
      PHASE_READ,
      PHASE_DONE
   } phase_type;

endpackage : irq_temp_pkg

/* File: rtl/irq_temp_sequencer.sv */
// Serial register port, interrupt request line and temperature conversion sequencer.
// Assumes clk is the master clock input and that serial pins come from another domain.
//
// Operation
// - A status read-with-reset releases the request line at the last falling serial edge of the command byte.
// - The line stays released until the fifteenth status bit has been shifted out.
// - After that the line goes low again only if an enabled flag is still pending.
// - Setting mode bit 5 arms a temperature conversion that starts at the next voltage zero crossing.
// - At that zero crossing the sensor is routed into the current channel converter.
// - The temperature result is written to its 8-bit register 96 master clock periods after the crossing.
// - Completion pulls the request line low when enable bit 5 is set.
// - The reading is two's complement, about 1.5 codes per degree, 0x00 near minus 25 degrees, uncalibrated.
// - Flags set on events regardless of enables, and any enabled set flag pulls the line low except during a read-with-reset hold.
// - Reading address 0x0C returns the status flags and then clears them.
// - An event arriving during the read-with-reset stays pending and is signalled afterwards.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module irq_temp_sequencer (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire irq_temp_pkg::spi_pins_type spi_pins,
   input  wire logic [15:0]                event_in,
   input  wire logic                       zero_cross,
   input  wire logic [7:0]                 sensor_code,
   output logic                            dout,
   output logic                            dout_oe,
   output logic                            irq_n_out,
   output logic                            irq_n_oe,
   output logic                            temp_route
);
   import irq_temp_pkg::*;

   spi_pins_type pins_meta_q;
   spi_pins_type pins_q;
   spi_pins_type pins_prev_q;

   phase_type    phase_q,    phase_d;
   logic [4:0]   bits_q,     bits_d;
   logic [4:0]   width_q,    width_d;
   logic [7:0]   cmd_q,      cmd_d;
   logic [15:0]  shift_q,    shift_d;
   logic [15:0]  mode_q,     mode_d;
   logic [15:0]  irq_en_q,   irq_en_d;
   logic [15:0]  status_q,   status_d;
   logic [7:0]   temp_q,     temp_d;
   logic         hold_q,     hold_d;
   logic         armed_q,    armed_d;
   logic         conv_q,     conv_d;
   logic [6:0]   conv_cnt_q, conv_cnt_d;
   logic         irq_oe_q,   irq_oe_d;

   logic         sclk_fall;
   logic         sclk_rise;
   logic         selected;
   logic         temp_done;
   logic [15:0]  events;
   logic [7:0]   cmd_next;
   logic [15:0]  wr_next;
   logic [5:0]   addr;

   function automatic logic [4:0] reg_width(input logic [5:0] a);
      reg_width = (a == ADDR_TEMP) ? TEMP_REG_BITS : WIDE_REG_BITS;
   endfunction : reg_width

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sclk_fall  = pins_prev_q.sclk & ~pins_q.sclk;
      sclk_rise  = ~pins_prev_q.sclk & pins_q.sclk;
      selected   = ~pins_q.cs_n;
      temp_done  = conv_q && (conv_cnt_q == 7'(TEMP_CYCLES - 1));
      events     = event_in;
      events[TEMP_EVENT_BIT] = event_in[TEMP_EVENT_BIT] | temp_done;
      cmd_next   = {cmd_q[6:0], pins_q.din};
      wr_next    = {shift_q[14:0], pins_q.din};
      addr       = cmd_next[5:0];

      phase_d    = phase_q;
      bits_d     = bits_q;
      width_d    = width_q;
      cmd_d      = cmd_q;
      shift_d    = shift_q;
      mode_d     = mode_q;
      irq_en_d   = irq_en_q;
      status_d   = status_q | events;
      temp_d     = temp_q;
      hold_d     = hold_q;
      armed_d    = armed_q;
      conv_d     = conv_q;
      conv_cnt_d = conv_cnt_q;

      // Temperature sequence. Arming is consumed by the crossing so one set gives one result.
      if (armed_q && zero_cross) begin
         armed_d    = 1'b0;
         conv_d     = 1'b1;
         conv_cnt_d = 7'h00;
      end else if (conv_q) begin
         conv_cnt_d = conv_cnt_q + 7'h01;
         if (temp_done) begin
            temp_d  = sensor_code;
            conv_d  = 1'b0;
            mode_d[MODE_TEMP_BIT] = 1'b0;
         end
      end

      if (!selected) begin
         // Deselect ends any frame; a cut-short status read must not leave the line parked high.
         phase_d = PHASE_CMD;
         bits_d  = 5'h00;
         shift_d = 16'h0000;
         hold_d  = 1'b0;
      end else begin
         unique case (phase_q)
            PHASE_CMD: begin
               if (sclk_fall) begin
                  cmd_d  = cmd_next;
                  bits_d = bits_q + 5'h01;
                  if (bits_q == CMD_BITS - 5'h01) begin
                     bits_d  = 5'h00;
                     width_d = reg_width(addr);
                     if (cmd_next[CMD_WRITE_BIT]) begin
                        phase_d = PHASE_WRITE;
                     end else begin
                        phase_d = PHASE_READ;
                        unique case (addr)
                           ADDR_MODE:   shift_d = mode_q;
                           ADDR_IRQ_EN: shift_d = irq_en_q;
                           ADDR_STATUS: shift_d = status_q;
                           ADDR_STAT_CLR: begin
                              shift_d  = status_q;
                              status_d = events;
                              hold_d   = 1'b1;
                           end
                           ADDR_TEMP:   shift_d = {temp_q, 8'h00};
                           default:     shift_d = 16'h0000;
                        endcase
                     end
                  end
               end
            end
            PHASE_WRITE: begin
               if (sclk_fall) begin
                  shift_d = wr_next;
                  bits_d  = bits_q + 5'h01;
                  if (bits_q == width_q - 5'h01) begin
                     phase_d = PHASE_DONE;
                     if (cmd_q[5:0] == ADDR_MODE) begin
                        mode_d = wr_next;
                        armed_d = wr_next[MODE_TEMP_BIT];
                     end
                     if (cmd_q[5:0] == ADDR_IRQ_EN) begin
                        irq_en_d = wr_next;
                     end
                  end
               end
            end
            PHASE_READ: begin
               if (sclk_rise && bits_q != 5'h00) begin
                  shift_d = {shift_q[14:0], 1'b0};
               end
               if (sclk_fall) begin
                  bits_d = bits_q + 5'h01;
                  if (bits_q == STATUS_HOLD_BITS - 5'h01) begin
                     hold_d = 1'b0;
                  end
                  if (bits_q == width_q - 5'h01) begin
                     phase_d = PHASE_DONE;
                  end
               end
            end
            PHASE_DONE: begin
               shift_d = 16'h0000;
            end
         endcase
      end

      // Any enabled flag, including ones set mid-read, drives the line once the hold ends.
      irq_oe_d = |(status_d & irq_en_d) & ~hold_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         // The serial clock rests high, so the synchroniser starts there to avoid a false edge.
         pins_meta_q <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
         pins_q      <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
         pins_prev_q <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
         phase_q     <= PHASE_CMD;
         bits_q      <= 5'h00;
         width_q     <= WIDE_REG_BITS;
         cmd_q       <= 8'h00;
         shift_q     <= 16'h0000;
         mode_q      <= MODE_RESET;
         irq_en_q    <= IRQ_EN_RESET;
         status_q    <= STATUS_RESET;
         temp_q      <= TEMP_RESET;
         hold_q      <= 1'b0;
         armed_q     <= 1'b0;
         conv_q      <= 1'b0;
         conv_cnt_q  <= 7'h00;
         irq_oe_q    <= 1'b0;
      end else begin
         pins_meta_q <= spi_pins;
         pins_q      <= pins_meta_q;
         pins_prev_q <= pins_q;
         phase_q     <= phase_d;
         bits_q      <= bits_d;
         width_q     <= width_d;
         cmd_q       <= cmd_d;
         shift_q     <= shift_d;
         mode_q      <= mode_d;
         irq_en_q    <= irq_en_d;
         status_q    <= status_d;
         temp_q      <= temp_d;
         hold_q      <= hold_d;
         armed_q     <= armed_d;
         conv_q      <= conv_d;
         conv_cnt_q  <= conv_cnt_d;
         irq_oe_q    <= irq_oe_d;
      end
   end

   // The request pin is open drain: it only ever pulls low.
   assign irq_n_out  = 1'b0;
   assign irq_n_oe   = irq_oe_q;
   assign dout       = shift_q[15];
   assign dout_oe    = selected;
   assign temp_route = conv_q;

endmodule : irq_temp_sequencer

/* File: verification/irq_temp_sequencer_properties.sv */
// Port checker for the request line, sensor routing and serial output enable.
// Assumes it is bound to irq_temp_sequencer and that clk is the master clock.
`timescale 1ns/1ps
module irq_temp_checker (
   input wire logic                       clk,
   input wire logic                       reset,
   input wire irq_temp_pkg::spi_pins_type spi_pins,
   input wire logic                       dout_oe,
   input wire logic                       irq_n_out,
   input wire logic                       irq_n_oe,
   input wire logic                       temp_route,
   input wire logic                       zero_cross
);
   import irq_temp_pkg::*;
   logic [7:0] route_cnt_q;
   logic [7:0] route_cnt_d;
   always_comb route_cnt_d = temp_route ? route_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) route_cnt_q <= 8'h00;
      else route_cnt_q <= route_cnt_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   property p_open_drain; irq_n_out == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("line value not low");
   property p_oe_on; $fell(spi_pins.cs_n) |-> ##[1:3] dout_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("output enable late");
   property p_oe_off; spi_pins.cs_n [*4] |-> !dout_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output enable stuck");
   property p_release; $fell(irq_n_oe) |-> !spi_pins.cs_n; endproperty
   a_release: assert property (p_release) else $error("release outside frame");
   property p_hold; $fell(irq_n_oe) |-> (!irq_n_oe) [*8]; endproperty
   a_hold: assert property (p_hold) else $error("release too short");
   property p_route_start; $rose(temp_route) |-> $past(zero_cross); endproperty
   a_route_start: assert property (p_route_start) else $error("route without crossing");
   property p_route_len; $fell(temp_route) |-> route_cnt_q == 8'h60; endproperty
   a_route_len: assert property (p_route_len) else $error("conversion length wrong");
   property p_one_shot; $fell(temp_route) |=> !temp_route; endproperty
   a_one_shot: assert property (p_one_shot) else $error("conversion repeated");
   property p_reset_quiet; $fell(reset) |-> !irq_n_oe && !temp_route && !dout_oe; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
   c_release: cover property ($fell(irq_n_oe));
   c_rearm: cover property ($rose(irq_n_oe) && !spi_pins.cs_n);
   c_route: cover property ($fell(temp_route));
endmodule : irq_temp_checker
bind irq_temp_sequencer irq_temp_checker i_checker (.clk(clk), .reset(reset),
   .spi_pins(spi_pins), .dout_oe(dout_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
   .temp_route(temp_route), .zero_cross(zero_cross));

/* File: verification/host_mcu_model.sv */
// Host controller model: serial frames and an edge-triggered interrupt flag.
// Assumes a 100 ns clk; the serial clock runs at 800 ns in frames and rests high.
`timescale 1ns/1ps
module host_mcu_model (
   input wire logic                  clk,
   input wire logic                  irq_line,
   input wire logic                  dout,
   output irq_temp_pkg::spi_pins_type spi_pins
);
   import irq_temp_pkg::*;
   logic ext_flag = 1'b0;
   logic irq_on = 1'b1;
   initial spi_pins = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
   // Edges are latched even while service runs, so a late event is not lost.
   always @(negedge irq_line) ext_flag = 1'b1;
   task automatic frame(input logic [7:0] cmd, input logic [15:0] wdata, input int nbits,
                        output logic [15:0] rdata);
      logic [23:0] bits;
      bits = {cmd, wdata};
      rdata = 16'h0000;
      spi_pins.cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8 + nbits; i++) begin
         spi_pins.din <= bits[23 - i];
         repeat (4) @(posedge clk);
         spi_pins.sclk <= 1'b0;
         // Output shifts only after rising edges (its first bit loads after the command byte), so mid-low is the safe sample point.
         repeat (2) @(posedge clk);
         if (i >= 8) rdata = {rdata[14:0], dout};
         repeat (2) @(posedge clk);
         spi_pins.sclk <= 1'b1;
      end
      repeat (8) @(posedge clk);
      spi_pins.cs_n <= 1'b1;
      spi_pins.din <= ~spi_pins.din;
      repeat (4) @(posedge clk);
   endtask : frame
   task automatic service(output logic [15:0] st);
      irq_on = 1'b0;
      ext_flag = 1'b0;
      frame({2'b00, ADDR_STAT_CLR}, 16'h0000, 16, st);
      irq_on = 1'b1;
   endtask : service
endmodule : host_mcu_model

/* File: verification/test_irq_temp_sequencer.sv */
// Self-checking bench: register reads, request line release and temperature conversion.
// Assumes the host model drives the serial pins; the bench drives events and sensor code.
`timescale 1ns/1ps
module test_irq_temp_sequencer;
   import irq_temp_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] event_in = 16'h0000;
   logic zero_cross = 1'b0;
   logic [7:0] sensor_code = 8'h00;
   spi_pins_type spi_pins;
   logic dout, dout_oe, irq_n_out, irq_n_oe, temp_route;
   wire irq_line = irq_n_oe ? irq_n_out : 1'b1;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   logic [15:0] rd;
   logic [15:0] st;
   always #50 clk = ~clk;
   irq_temp_sequencer i_dut (.clk(clk), .reset(reset), .spi_pins(spi_pins),
      .event_in(event_in), .zero_cross(zero_cross), .sensor_code(sensor_code), .dout(dout),
      .dout_oe(dout_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .temp_route(temp_route));
   host_mcu_model i_host (.clk(clk), .irq_line(irq_line), .dout(dout), .spi_pins(spi_pins));
   ////////////////////////////////////////////////////////////////////////////
   task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : compare
   task automatic test_done;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic pulse(input logic [15:0] ev, input logic zc);
      event_in <= ev;
      zero_cross <= zc;
      @(posedge clk);
      event_in <= 16'h0000;
      zero_cross <= 1'b0;
      @(posedge clk);
   endtask : pulse
   task automatic test_reset_values;
      logic [5:0] a [5] = '{ADDR_MODE, ADDR_IRQ_EN, ADDR_STATUS, ADDR_TEMP, 6'h15};
      logic [15:0] e [5] = '{MODE_RESET, IRQ_EN_RESET, STATUS_RESET, {8'h00, TEMP_RESET}, 16'h0};
      for (int i = 0; i < 5; i++) begin
         i_host.frame({2'b00, a[i]}, 16'h0000, (a[i] == ADDR_TEMP) ? 8 : 16, rd);
         compare("reset value", e[i], rd);
      end
   endtask : test_reset_values
   task automatic test_flag_no_enable;
      pulse(16'h0001, 1'b0);
      repeat (2) @(posedge clk);
      compare("line masked", 16'h0001, irq_line);
      i_host.frame({2'b00, ADDR_STATUS}, 16'h0000, 16, rd);
      compare("flag set", 16'h0001, rd);
      i_host.service(st);
      i_host.frame({2'b00, ADDR_STATUS}, 16'h0000, 16, rd);
      compare("flag cleared", 16'h0000, rd);
   endtask : test_flag_no_enable
   task automatic test_pending;
      i_host.frame(8'h8A, 16'hFFFF, 16, rd);
      pulse(16'h0008, 1'b0);
      repeat (2) @(posedge clk);
      compare("line low", 16'h0000, irq_line);
      compare("edge seen", 16'h0001, i_host.ext_flag);
      fork
         i_host.service(st);
         begin
            repeat (120) @(posedge clk);
            compare("released", 16'h0001, irq_line);
            pulse(16'h0004, 1'b0);
            repeat (10) @(posedge clk);
            compare("held high", 16'h0001, irq_line);
         end
      join
      compare("status", 16'h0008, st);
      compare("pending low", 16'h0000, irq_line);
      compare("edge again", 16'h0001, i_host.ext_flag);
      i_host.service(st);
      compare("late status", 16'h0004, st);
      compare("stays high", 16'h0001, irq_line);
   endtask : test_pending
   task automatic test_temperature;
      i_host.frame(8'h8A, 16'h0020, 16, rd);
      sensor_code <= 8'hC4;
      pulse(16'h0000, 1'b1);
      compare("no arm", 16'h0000, temp_route);
      i_host.frame({2'b10, ADDR_MODE}, 16'h0020, 16, rd);
      repeat (20) @(posedge clk);
      compare("waits crossing", 16'h0000, temp_route);
      pulse(16'h0000, 1'b1);
      compare("routed", 16'h0001, temp_route);
      repeat (94) @(posedge clk);
      compare("still routed", 16'h0001, temp_route);
      repeat (4) @(posedge clk);
      compare("done low", 16'h0000, irq_line);
      i_host.frame({2'b00, ADDR_TEMP}, 16'h0000, 8, rd);
      compare("reading", 16'h00C4, rd);
      i_host.service(st);
      compare("done flag", 16'h0020, st);
      i_host.frame({2'b00, ADDR_MODE}, 16'h0000, 16, rd);
      compare("mode cleared", 16'h0000, rd);
   endtask : test_temperature
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      test_reset_values;
      test_flag_no_enable;
      test_pending;
      test_temperature;
      test_done;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         test_done;
      end
   end
endmodule : test_irq_temp_sequencer
